// ===== hw/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

  // configuration byte offsets
  localparam logic [7:0] OFS_SUBCLASS = 8'h0a;
  localparam logic [7:0] OFS_BASE_CLASS = 8'h0b;
  localparam logic [7:0] OFS_HEADER = 8'h0e;
  localparam logic [7:0] OFS_UP_BUS = 8'h18;
  localparam logic [7:0] OFS_DOWN_BUS = 8'h19;
  localparam logic [7:0] OFS_HIGH_BUS = 8'h1a;
  localparam logic [7:0] OFS_TENURE = 8'h1b;
  localparam logic [7:0] OFS_IO_START = 8'h1c;
  localparam logic [7:0] OFS_IO_END = 8'h1d;
  localparam logic [7:0] OFS_ERR_LO = 8'h1e;
  localparam logic [7:0] OFS_ERR_HI = 8'h1f;
  localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h3e;

  // constant and reset values
  localparam logic [7:0] SUBCLASS_VAL = 8'h04;
  localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
  localparam logic [7:0] HEADER_VAL = 8'h01;
  localparam logic [7:0] UP_BUS_VAL = 8'h00;
  localparam logic [7:0] DOWN_BUS_RST = 8'h00;
  localparam logic [7:0] HIGH_BUS_RST = 8'h00;
  localparam logic [4:0] TENURE_RST = 5'h00;
  localparam logic [3:0] IO_START_RST = 4'hf;
  localparam logic [3:0] IO_END_RST = 4'h0;
  localparam logic [15:0] ERR_FLAGS_RST = 16'h02a0;
  localparam logic [15:0] ERR_FIXED_MASK = 16'h02a0;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  localparam logic PAR_RESP_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // field positions
  localparam int TENURE_LSB = 3;
  localparam int IO_FIELD_LSB = 4;
  localparam int ERR_PARITY_BIT = 15;
  localparam int ERR_SYSERR_BIT = 14;
  localparam int ERR_MABORT_BIT = 13;
  localparam int ERR_TABORT_BIT = 12;
  localparam int ERR_INIT_PAR_BIT = 8;
  localparam int PAR_RESP_BIT = 0;

  // io window fill of the low address bits
  localparam logic [11:0] IO_START_FILL = 12'h000;
  localparam logic [11:0] IO_END_FILL = 12'hfff;

  localparam int NUM_FLAGS = 5;

endpackage

// ===== hw/sticky_flag.sv
`timescale 1ns/100ps
`default_nettype none

module sticky_flag (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // event and software clear
  input wire logic set_i,
  input wire logic clear_i,
  // state
  output logic flag_o
);

  logic flag_q;
  logic flag_d;

  // set wins over a clear in the same cycle so no event is lost
  assign flag_d = set_i | (flag_q & ~clear_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule

`default_nettype wire

// ===== hw/io_window_match.sv
`timescale 1ns/100ps
`default_nettype none

module io_window_match
  import bridge_cfg_pkg::*;
(
  // window fields
  input wire logic [3:0] start_field_i,
  input wire logic [3:0] end_field_i,
  // address under test
  input wire logic [15:0] addr_i,
  // decision
  output logic hit_o
);

  logic [15:0] win_lo;
  logic [15:0] win_hi;
  logic above_lo;
  logic below_hi;

  assign win_lo = {start_field_i, IO_START_FILL};
  assign win_hi = {end_field_i, IO_END_FILL};
  assign above_lo = (addr_i >= win_lo);
  assign below_hi = (addr_i <= win_hi);
  // an inverted window (start above end) can never satisfy both compares
  assign hit_o = above_lo & below_hi;

endmodule

`default_nettype wire

// ===== hw/bridge_cfg_header.sv
// Contract
// - sub-class byte reads 04h, read-only
// - base class byte reads 06h, read-only
// - header layout reads 01h, no storage
// - upstream bus number hardwired to 00h
// - downstream bus number read/write, reset 00h
// - highest bus below read/write, reset 00h
// - tenure count bits 7:3, zero disables
// - forward io inside start..end inclusive
// - start bits 7:4 give A15:12, low zero
// - end bits 7:4 give A15:12, low FFFh
// - only upper nibble of window bytes writable
// - bit 15 set on any port parity error
// - bit 14 set on port system error
// - bit 13 set on master abort
// - bit 12 set on target abort
// - bit 8 needs perr, initiator, enable
// - flags clear by writing one only
// - error register resets 02A0h, reserved read-only
// - parity response enable is 3Eh bit 0
`timescale 1ns/100ps
`default_nettype none

module bridge_cfg_header
  import bridge_cfg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // configuration access, one byte per request
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // processor io routing
  input wire logic io_req_i,
  input wire logic [15:0] io_addr_i,
  output logic io_fwd_o,
  output logic io_done_o,
  // graphics port events
  input wire logic port_parity_err_i,
  input wire logic port_syserr_i,
  input wire logic port_master_abort_i,
  input wire logic port_target_abort_i,
  input wire logic port_perr_seen_i,
  input wire logic port_initiator_i,
  // settings to the port logic
  output logic [7:0] downstream_bus_number_o,
  output logic [7:0] highest_bus_below_o,
  output logic [4:0] port_tenure_count_o,
  output logic port_tenure_enable_o,
  output logic port_parity_response_enable_o
);

  // reset release synchroniser
  logic rst_meta_q;
  logic rst_sync_q;

  // assertion takes effect at once; only the release waits for two edges
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 1'b0;
    end else begin
      rst_sync_q <= rst_meta_q;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_q;

  // storage
  // only the writable bits of each register are stored
  logic [7:0] down_bus_q;
  logic [7:0] high_bus_q;
  logic [4:0] tenure_q;
  logic [3:0] io_start_q;
  logic [3:0] io_end_q;
  logic par_resp_q;

  // address decode
  // a read in the same cycle as a write still sees the old value
  logic hit_down_bus;
  logic hit_high_bus;
  logic hit_tenure;
  logic hit_io_start;
  logic hit_io_end;
  logic hit_err_hi;
  logic hit_bridge_control_reg;

  assign hit_down_bus = (cfg_addr_i == OFS_DOWN_BUS);
  assign hit_high_bus = (cfg_addr_i == OFS_HIGH_BUS);
  assign hit_tenure = (cfg_addr_i == OFS_TENURE);
  assign hit_io_start = (cfg_addr_i == OFS_IO_START);
  assign hit_io_end = (cfg_addr_i == OFS_IO_END);
  assign hit_err_hi = (cfg_addr_i == OFS_ERR_HI);
  assign hit_bridge_control_reg = (cfg_addr_i == OFS_BRIDGE_CTRL);

  logic wr_down_bus;
  logic wr_high_bus;
  logic wr_tenure;
  logic wr_io_start;
  logic wr_io_end;
  logic wr_err_hi;
  logic wr_bridge_control_reg;

  assign wr_down_bus = cfg_wr_i & hit_down_bus;
  assign wr_high_bus = cfg_wr_i & hit_high_bus;
  assign wr_tenure = cfg_wr_i & hit_tenure;
  assign wr_io_start = cfg_wr_i & hit_io_start;
  assign wr_io_end = cfg_wr_i & hit_io_end;
  assign wr_err_hi = cfg_wr_i & hit_err_hi;
  assign wr_bridge_control_reg = cfg_wr_i & hit_bridge_control_reg;

  // next values: a write replaces the field, otherwise it holds
  logic [7:0] down_bus_d;
  logic [7:0] high_bus_d;
  logic [4:0] tenure_d;
  logic [3:0] io_start_d;
  logic [3:0] io_end_d;
  logic par_resp_d;

  assign down_bus_d = wr_down_bus ? cfg_wdata_i : down_bus_q;
  assign high_bus_d = wr_high_bus ? cfg_wdata_i : high_bus_q;
  // the low three bits are not kept, so they read back as zero
  assign tenure_d = wr_tenure ? cfg_wdata_i[7:TENURE_LSB] : tenure_q;
  // the reserved low nibble is dropped here and never stored
  assign io_start_d = wr_io_start ? cfg_wdata_i[7:IO_FIELD_LSB] : io_start_q;
  assign io_end_d = wr_io_end ? cfg_wdata_i[7:IO_FIELD_LSB] : io_end_q;
  // only the parity response bit of the bridge control byte is kept
  assign par_resp_d = wr_bridge_control_reg ? cfg_wdata_i[PAR_RESP_BIT] : par_resp_q;

  // one short block per register keeps each reset value beside its flop
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      down_bus_q <= DOWN_BUS_RST;
    end else begin
      down_bus_q <= down_bus_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      high_bus_q <= HIGH_BUS_RST;
    end else begin
      high_bus_q <= high_bus_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tenure_q <= TENURE_RST;
    end else begin
      tenure_q <= tenure_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_start_q <= IO_START_RST;
    end else begin
      io_start_q <= io_start_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_end_q <= IO_END_RST;
    end else begin
      io_end_q <= io_end_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      par_resp_q <= PAR_RESP_RST;
    end else begin
      par_resp_q <= par_resp_d;
    end
  end

  // error flags: index 0..4 map to bits 15,14,13,12,8
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flag_val;

  assign flag_set[0] = port_parity_err_i;
  assign flag_set[1] = port_syserr_i;
  assign flag_set[2] = port_master_abort_i;
  assign flag_set[3] = port_target_abort_i;
  // only counts when the bridge itself started the failing cycle
  assign flag_set[4] = port_perr_seen_i & port_initiator_i & par_resp_q;

  // a write of one clears, a write of zero leaves the flag alone
  assign flag_clr[0] = wr_err_hi & cfg_wdata_i[ERR_PARITY_BIT-8];
  assign flag_clr[1] = wr_err_hi & cfg_wdata_i[ERR_SYSERR_BIT-8];
  assign flag_clr[2] = wr_err_hi & cfg_wdata_i[ERR_MABORT_BIT-8];
  assign flag_clr[3] = wr_err_hi & cfg_wdata_i[ERR_TABORT_BIT-8];
  assign flag_clr[4] = wr_err_hi & cfg_wdata_i[ERR_INIT_PAR_BIT-8];

  // one sticky cell per flag; the constant ones bits are never stored
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      sticky_flag u_flag (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .set_i(flag_set[gi]),
        .clear_i(flag_clr[gi]),
        .flag_o(flag_val[gi])
      );
    end
  endgenerate

  logic [15:0] err_word;
  always_comb begin
    err_word = ERR_FIXED_MASK;
    err_word[ERR_PARITY_BIT] = flag_val[0];
    err_word[ERR_SYSERR_BIT] = flag_val[1];
    err_word[ERR_MABORT_BIT] = flag_val[2];
    err_word[ERR_TABORT_BIT] = flag_val[3];
    err_word[ERR_INIT_PAR_BIT] = flag_val[4];
  end

  // read mux
  // unmapped offsets read as zero and take no writes
  logic [7:0] rd_mux;
  always_comb begin
    unique case (cfg_addr_i)
      OFS_SUBCLASS: rd_mux = SUBCLASS_VAL;
      OFS_BASE_CLASS: rd_mux = BASE_CLASS_VAL;
      OFS_HEADER: rd_mux = HEADER_VAL;
      OFS_UP_BUS: rd_mux = UP_BUS_VAL;
      OFS_DOWN_BUS: rd_mux = down_bus_q;
      OFS_HIGH_BUS: rd_mux = high_bus_q;
      OFS_TENURE: rd_mux = {tenure_q, 3'h0};
      OFS_IO_START: rd_mux = {io_start_q, 4'h0};
      OFS_IO_END: rd_mux = {io_end_q, 4'h0};
      OFS_ERR_LO: rd_mux = err_word[7:0];
      OFS_ERR_HI: rd_mux = err_word[15:8];
      OFS_BRIDGE_CTRL: rd_mux = {7'h00, par_resp_q};
      default: rd_mux = UNMAPPED_VAL;
    endcase
  end

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // read data holds between reads, so a slow reader still finds it
  assign rdata_d = cfg_rd_i ? rd_mux : rdata_q;
  assign rvalid_d = cfg_rd_i;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
    end
  end

  // io routing, registered so the decision leaves from a flop
  // an access in the cycle of a window write still uses the old fields
  logic io_hit;
  io_window_match u_io_win (
    .start_field_i(io_start_q),
    .end_field_i(io_end_q),
    .addr_i(io_addr_i),
    .hit_o(io_hit)
  );

  logic io_fwd_q;
  logic io_fwd_d;
  logic io_done_q;
  logic io_done_d;

  // the answer always comes one cycle after the request, hit or not
  assign io_done_d = io_req_i;
  assign io_fwd_d = io_req_i & io_hit;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_fwd_q <= 1'b0;
    end else begin
      io_fwd_q <= io_fwd_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      io_done_q <= 1'b0;
    end else begin
      io_done_q <= io_done_d;
    end
  end

  logic tenure_en_q;
  logic tenure_en_d;

  // a zero count leaves the timer disabled
  assign tenure_en_d = (tenure_q != TENURE_RST);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tenure_en_q <= 1'b0;
    end else begin
      tenure_en_q <= tenure_en_d;
    end
  end

  // every output below leaves straight from a flop
  assign cfg_rdata_o = rdata_q;
  assign cfg_rvalid_o = rvalid_q;
  assign io_fwd_o = io_fwd_q;
  assign io_done_o = io_done_q;
  assign downstream_bus_number_o = down_bus_q;
  assign highest_bus_below_o = high_bus_q;
  assign port_tenure_count_o = tenure_q;
  assign port_tenure_enable_o = tenure_en_q;
  assign port_parity_response_enable_o = par_resp_q;

endmodule

`default_nettype wire

// ===== tb/bridge_cfg_header_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bridge_cfg_header_checker
  import bridge_cfg_pkg::*;
(
  // watched ports
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire logic io_req_i,
  input wire logic io_done_o,
  input wire logic port_syserr_i,
  input wire logic port_perr_seen_i,
  input wire logic port_initiator_i,
  input wire logic [7:0] downstream_bus_number_o,
  input wire logic [4:0] port_tenure_count_o,
  input wire logic port_parity_response_enable_o
);
  // a write in the same cycle would make the read ambiguous
  wire logic rd_hi = cfg_rd_i && cfg_addr_i == OFS_ERR_HI && !cfg_wr_i;
  wire logic [4:0] wr_cnt = cfg_wdata_i[7:3];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_subclass_read: assert property (cfg_rd_i && cfg_addr_i == OFS_SUBCLASS |=>
    cfg_rvalid_o && cfg_rdata_o == SUBCLASS_VAL) else $error("subclass read wrong");
  chk_down_bus_wr: assert property (cfg_wr_i && cfg_addr_i == OFS_DOWN_BUS |=>
    downstream_bus_number_o == $past(cfg_wdata_i)) else $error("bus number not taken");
  chk_tenure_wr: assert property (cfg_wr_i && cfg_addr_i == OFS_TENURE |=>
    port_tenure_count_o == $past(wr_cnt)) else $error("tenure count not taken");
  chk_io_answer: assert property (io_req_i |=> io_done_o)
    else $error("io decision missing");
  chk_syserr_flag: assert property (port_syserr_i ##1 rd_hi |=> cfg_rdata_o[6])
    else $error("system error flag not set");
  chk_init_parity: assert property (port_perr_seen_i && port_initiator_i &&
    port_parity_response_enable_o ##1 rd_hi |=> cfg_rdata_o[0]) else $error("bit 8 not set");
  chk_err_low_byte: assert property (cfg_rd_i && cfg_addr_i == OFS_ERR_LO |=>
    cfg_rdata_o == ERR_FLAGS_RST[7:0]) else $error("error low byte wrong");
  chk_par_enable_wr: assert property (cfg_wr_i && cfg_addr_i == OFS_BRIDGE_CTRL |=>
    {7'h00, port_parity_response_enable_o} == ($past(cfg_wdata_i) & 8'h01))
    else $error("parity enable not taken");
  cover property (io_req_i ##1 io_done_o);
  cover property (port_syserr_i ##1 rd_hi);
  cover property (cfg_wr_i && cfg_addr_i == OFS_ERR_HI);
endmodule
bind bridge_cfg_header bridge_cfg_header_checker i_bridge_cfg_header_checker (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
  .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_rvalid_o(cfg_rvalid_o), .io_req_i(io_req_i), .io_done_o(io_done_o),
  .port_syserr_i(port_syserr_i), .port_perr_seen_i(port_perr_seen_i),
  .port_initiator_i(port_initiator_i), .downstream_bus_number_o(downstream_bus_number_o),
  .port_tenure_count_o(port_tenure_count_o),
  .port_parity_response_enable_o(port_parity_response_enable_o));
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bridge_cfg_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] e;} row_t;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic io_req = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [15:0] io_addr = 16'h0000;
  // parity, syserr, master abort, target abort, perr seen, initiator
  logic [5:0] evs = 6'h00;
  logic rvalid, io_fwd, io_done, ten_en, par_en;
  logic [7:0] rdata, down_bus, high_bus, got;
  logic [4:0] ten_cnt;
  int fail_count = 0;
  int samples_checked = 0;
  // offset, reset value, write, readback
  row_t rows [13] = '{'{8'h0a, 8'h04, 8'hff, 8'h04}, '{8'h0b, 8'h06, 8'hff, 8'h06},
    '{8'h0e, 8'h01, 8'hff, 8'h01}, '{8'h18, 8'h00, 8'hff, 8'h00},
    '{8'h19, 8'h00, 8'h5a, 8'h5a}, '{8'h1a, 8'h00, 8'hc3, 8'hc3},
    '{8'h1b, 8'h00, 8'hff, 8'hf8}, '{8'h1c, 8'hf0, 8'h3f, 8'h30},
    '{8'h1d, 8'h00, 8'h5f, 8'h50}, '{8'h1e, 8'ha0, 8'hff, 8'ha0},
    '{8'h1f, 8'h02, 8'hff, 8'h02}, '{8'h3e, 8'h00, 8'h01, 8'h01},
    '{8'h40, 8'h00, 8'hff, 8'h00}};

  bridge_cfg_header i_bridge_cfg_header (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(addr), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
    .io_req_i(io_req), .io_addr_i(io_addr), .io_fwd_o(io_fwd), .io_done_o(io_done),
    .port_parity_err_i(evs[5]), .port_syserr_i(evs[4]), .port_master_abort_i(evs[3]),
    .port_target_abort_i(evs[2]), .port_perr_seen_i(evs[1]), .port_initiator_i(evs[0]),
    .downstream_bus_number_o(down_bus), .highest_bus_below_o(high_bus),
    .port_tenure_count_o(ten_cnt), .port_tenure_enable_o(ten_en),
    .port_parity_response_enable_o(par_en));

  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    step();
    wr = 1'b1;
    addr = a;
    wdata = d;
    step();
    wr = 1'b0;
  endtask

  // also ends any event pulse, so flags are read the cycle after they are raised
  task automatic cfg_read(input logic [7:0] a);
    step();
    evs = 6'h00;
    rd = 1'b1;
    addr = a;
    step();
    rd = 1'b0;
    for (int i = 0; i < 4 && rvalid !== 1'b1; i++) step();
    if (rvalid !== 1'b1) begin
      fail_count++;
      results();
    end
    got = rdata;
  endtask

  task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    cfg_write(a, d);
    cfg_read(a);
    check8("readback", e, got);
  endtask

  task automatic io_check(input logic [15:0] a, input logic e);
    step();
    io_req = 1'b1;
    io_addr = a;
    step();
    io_req = 1'b0;
    check8("io_done", 8'h01, {7'h00, io_done});
    check8("io_fwd", {7'h00, e}, {7'h00, io_fwd});
  endtask

  task automatic ev(input logic [5:0] v, input logic [7:0] e);
    step();
    evs = v;
    cfg_read(OFS_ERR_HI);
    check8("error flags", e, got);
  endtask

  initial begin
    do_reset();
    io_check(16'hf000, 1'b0);
    io_check(16'h0fff, 1'b0);
    foreach (rows[k]) begin
      cfg_read(rows[k].a);
      check8("reset value", rows[k].r, got);
      wrc(rows[k].a, rows[k].w, rows[k].e);
    end
    check8("downstream bus", 8'h5a, down_bus);
    check8("highest bus", 8'hc3, high_bus);
    check8("parity enable", 8'h01, {7'h00, par_en});
    check8("tenure", 8'h3f, {2'b00, ten_en, ten_cnt});
    $display("test register table done");
    io_check(16'h2fff, 1'b0);
    io_check(16'h3000, 1'b1);
    io_check(16'h5fff, 1'b1);
    io_check(16'h6000, 1'b0);
    $display("test io window done");
    ev(6'b000011, 8'h03);
    wrc(OFS_ERR_HI, 8'h00, 8'h03);
    wrc(OFS_ERR_HI, 8'h01, 8'h02);
    cfg_write(OFS_BRIDGE_CTRL, 8'h00);
    check8("parity enable off", 8'h00, {7'h00, par_en});
    ev(6'b100011, 8'h82);
    ev(6'b011100, 8'hf2);
    wrc(OFS_ERR_HI, 8'h80, 8'h72);
    wrc(OFS_ERR_HI, 8'hff, 8'h02);
    // event and clear of the same flag in one cycle: the flag must stay set
    step();
    evs = 6'b010000;
    wr = 1'b1;
    addr = OFS_ERR_HI;
    wdata = 8'hff;
    step();
    wr = 1'b0;
    evs = 6'h00;
    cfg_read(OFS_ERR_HI);
    check8("set beats clear", 8'h42, got);
    $display("test error flags done");
    do_reset();
    check8("tenure after reset", 8'h00, {2'b00, ten_en, ten_cnt});
    check8("parity enable after reset", 8'h00, {7'h00, par_en});
    cfg_read(OFS_ERR_HI);
    check8("flags after reset", 8'h02, got);
    cfg_read(OFS_DOWN_BUS);
    check8("bus after reset", 8'h00, got);
    cfg_read(OFS_IO_START);
    check8("start after reset", 8'hf0, got);
    io_check(16'h3000, 1'b0);
    $display("test mid reset done");
    results();
  end
endmodule
`default_nettype wire
